// *** design/i2csw_pkg.sv ***
/*
  package for the eight-way i2c channel switch: address, widths and reset values.
  assumes nothing beyond a systemverilog compiler.
*/
package i2csw_pkg;
  localparam int         DATA_W       = 8;
  localparam logic [3:0] ADDR_FIXED   = 4'he;
  localparam logic [7:0] SEL_RESET    = 8'h00;
  localparam int         BIT_CNT_W    = 4;
  localparam logic [3:0] LAST_BIT_IDX = 4'h7;
  localparam logic [3:0] ACK_BIT_IDX  = 4'h8;
  localparam int         SYNC_STAGES  = 2;
endpackage

// *** design/i2csw_sync.sv ***
/*
  two-flop synchroniser bank for the scl, sda and strap pins.
  assumes all inputs are asynchronous to clock.
*/
`timescale 1ns/10ps
module i2csw_sync #(
  parameter int W = 5
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] async_in,
  input  wire logic [W-1:0] reset_val,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;

  // reset value is a constant at the instance, so reset takes no port level
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stage1_r <= reset_val;
      stage2_r <= reset_val;
    end else if (clk_en) begin
      stage1_r <= async_in;
      stage2_r <= stage1_r;
    end
  end

  assign sync_out = stage2_r;
endmodule

// *** design/i2csw_top.sv ***
/*
  i2c slave of the eight-way channel switch: address match, channel-select register,
  stop-gated channel enables.
  assumes scl/sda open-drain with external pull-ups, scl far slower than clock,
  rst_n already combines the reset pin and the power-on indication.
*/
`timescale 1ns/10ps
module i2csw_top (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       addr_strap_bit0,
  input  wire logic       addr_strap_bit1,
  input  wire logic       addr_strap_bit2,
  output logic [7:0]      chan_en,
  output logic [7:0]      channel_select
);
  // ----------------------------------------------------------------
  // state encoding
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    I2CSW_IDLE = 5'h01,
    I2CSW_ADDR = 5'h02,
    I2CSW_WR   = 5'h04,
    I2CSW_RD   = 5'h08,
    I2CSW_SKIP = 5'h10
  } i2csw_state_t;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pins_s;
  i2csw_sync #(.W(5)) u_sync (
    .clock     (clock),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .async_in  ({addr_strap_bit2, addr_strap_bit1, addr_strap_bit0, scl_in, sda_in}),
    .reset_val (5'h03),
    .sync_out  (pins_s)
  );
  wire       scl_s = pins_s[1];
  wire       sda_s = pins_s[0];
  wire [2:0] strap_s = pins_s[4:2];

  // ----------------------------------------------------------------
  // bus condition detect
  // ----------------------------------------------------------------
  i2csw_state_t   state_r;
  logic           scl_d_r;
  logic           sda_d_r;
  logic [3:0]     bit_cnt_r;
  logic [7:0]     shift_r;
  logic [7:0]     sel_r;
  logic [7:0]     en_r;
  logic           pend_r;
  logic           drive_r;
  logic           addr_ok_r;
  logic           nack_r;
  logic [7:0]     tx_r;

  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire in_ack   = (bit_cnt_r == i2csw_pkg::ACK_BIT_IDX);
  wire byte_end = scl_rise & (bit_cnt_r == i2csw_pkg::LAST_BIT_IDX);
  wire [7:0] rx_byte = {shift_r[6:0], sda_s};
  wire addr_hit = (rx_byte[7:1] == {i2csw_pkg::ADDR_FIXED, strap_s});
  wire rd_req   = rx_byte[0];

  // ----------------------------------------------------------------
  // byte engine
  // ----------------------------------------------------------------
  // bit_cnt 0..7 are data bits, 8 is the ack slot; it advances on scl fall
  // so sda changes only while scl is low.
  i2csw_state_t state_nxt;
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      I2CSW_IDLE: state_nxt = state_r;
      I2CSW_ADDR: begin
        if (byte_end) begin
          if (!addr_hit) begin
            state_nxt = I2CSW_SKIP;
          end else if (rd_req) begin
            state_nxt = I2CSW_RD;
          end else begin
            state_nxt = I2CSW_WR;
          end
        end
      end
      I2CSW_WR:   state_nxt = state_r;
      I2CSW_RD: begin
        if (scl_rise && in_ack && sda_s) begin
          state_nxt = I2CSW_SKIP;
        end
      end
      I2CSW_SKIP: state_nxt = state_r;
      default:    state_nxt = I2CSW_IDLE;
    endcase
    if (start_c) begin
      state_nxt = I2CSW_ADDR;
    end else if (stop_c) begin
      state_nxt = I2CSW_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r   <= I2CSW_IDLE;
      scl_d_r   <= 1'b1;
      sda_d_r   <= 1'b1;
      bit_cnt_r <= '0;
      shift_r   <= i2csw_pkg::SEL_RESET;
    end else if (clk_en) begin
      state_r <= state_nxt;
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      if (start_c) begin
        // the scl fall that closes the start wraps this to bit 0
        bit_cnt_r <= i2csw_pkg::ACK_BIT_IDX;
      end else if (scl_fall) begin
        bit_cnt_r <= in_ack ? 4'h0 : bit_cnt_r + 4'h1;
      end
      if (scl_rise && !in_ack) begin
        shift_r <= rx_byte;
      end
    end
  end

  // ----------------------------------------------------------------
  // select register and stop-gated enables
  // ----------------------------------------------------------------
  wire wr_byte = (state_r == I2CSW_WR) & byte_end;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sel_r  <= i2csw_pkg::SEL_RESET;
      en_r   <= i2csw_pkg::SEL_RESET;
      pend_r <= 1'b0;
    end else if (clk_en) begin
      if (wr_byte) begin
        sel_r  <= rx_byte;
        pend_r <= 1'b1;
      end
      // all eight bits copied at once, any mix allowed
      if (stop_c && pend_r) begin
        en_r   <= sel_r;
        pend_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // sda drive: ack and read data
  // ----------------------------------------------------------------
  // the state has already left I2CSW_ADDR when the ack slot opens,
  // so a match is held here until the next scl fall
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      addr_ok_r <= 1'b0;
    end else if (clk_en) begin
      if (start_c || stop_c || scl_fall) begin
        addr_ok_r <= 1'b0;
      end else if ((state_r == I2CSW_ADDR) && byte_end && addr_hit) begin
        addr_ok_r <= 1'b1;
      end
    end
  end
  wire acked = (state_r == I2CSW_WR) | addr_ok_r;
  wire rd_go = (state_r == I2CSW_RD);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      drive_r <= 1'b0;
      nack_r  <= 1'b0;
      tx_r    <= i2csw_pkg::SEL_RESET;
    end else if (clk_en) begin
      if (start_c || stop_c) begin
        drive_r <= 1'b0;
        nack_r  <= 1'b0;
      end else if (scl_fall) begin
        if (bit_cnt_r == i2csw_pkg::LAST_BIT_IDX) begin
          // ack after own address or each written byte
          drive_r <= acked;
          nack_r  <= 1'b0;
        end else if (in_ack) begin
          // first data bit of a read byte, snapshot taken now
          if (rd_go) begin
            tx_r    <= {sel_r[6:0], 1'b0};
            drive_r <= ~sel_r[7];
          end else begin
            drive_r <= 1'b0;
          end
        end else if (rd_go) begin
          drive_r <= ~tx_r[7];
          tx_r    <= {tx_r[6:0], 1'b0};
        end
      end else if (state_nxt == I2CSW_SKIP) begin
        drive_r <= 1'b0;
      end
    end
  end

  assign sda_out        = 1'b0;
  assign sda_oe         = drive_r;
  assign chan_en        = en_r;
  assign channel_select = sel_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // the edge that releases reset still sees the clear made during reset
  enables_at_stop_a: assert property ($changed(en_r) && $past(rst_n) |-> $past(stop_c))
    else $error("channel enables changed without a stop");
  enable_copy_a: assert property (clk_en && stop_c && pend_r |=> en_r == $past(sel_r))
    else $error("enables differ from stored selection");
  reg_write_a: assert property (clk_en && wr_byte |=> sel_r == $past(rx_byte))
    else $error("written byte not stored");
  sel_stable_a: assert property ($changed(sel_r) && $past(rst_n) |-> $past(wr_byte))
    else $error("select register changed outside a write");
  skip_quiet_a: assert property (state_r == I2CSW_SKIP && !start_c |=> !sda_oe)
    else $error("sda driven for foreign address");
  addr_ack_a: assert property (clk_en && addr_ok_r && scl_fall |=> sda_oe)
    else $error("address ack sequence broken");
  reset_clear_a: assert property (!$past(rst_n) |-> en_r == i2csw_pkg::SEL_RESET)
    else $error("enables not cleared by reset");
  wrong_addr_a: assert property (clk_en && state_r == I2CSW_ADDR && byte_end && !addr_hit
    |=> state_r == I2CSW_SKIP)
    else $error("foreign address not skipped");

  wr_seen_c:   cover property (wr_byte);
  rd_seen_c:   cover property (state_r == I2CSW_RD && scl_fall);
  commit_c:    cover property (stop_c && pend_r);
endmodule

// *** verification/i2csw_master_model.sv ***
/*
  upstream i2c master model: drives scl and pulls sda low, byte and frame tasks.
  assumes the bench resolves sda with a pull-up and runs clock at 100 mhz.
*/
`timescale 1ns/10ps
module i2csw_master_model (
  input  wire logic clock,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_pull
);
  // scl rests high between frames; a quarter of the 160 ns bit is 4 clocks
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic qtr();
    repeat (4) @(posedge clock);
  endtask
  task automatic start();
    sda_pull <= 1'b0;
    qtr();
    sda_pull <= 1'b1;
    qtr();
    scl <= 1'b0;
    qtr();
  endtask
  task automatic stop();
    sda_pull <= 1'b1;
    qtr();
    scl <= 1'b1;
    qtr();
    sda_pull <= 1'b0;
    qtr();
  endtask
  // nine bits, msb first; nb is the ninth bit driven (1 = released)
  task automatic xfer(input logic [7:0] tx, input logic nb, output logic [7:0] rx,
                      output logic ack_in);
    logic [8:0] sh;
    logic [8:0] got;
    sh = {tx, nb};
    got = 9'h000;
    repeat (9) begin
      sda_pull <= ~sh[8];
      sh = sh << 1;
      qtr();
      scl <= 1'b1;
      qtr();
      got = {got[7:0], sda_wire};
      qtr();
      scl <= 1'b0;
      qtr();
    end
    rx = got[8:1];
    ack_in = got[0];
  endtask
endmodule

// *** verification/tb_top.sv ***
/*
  self-checking bench of the i2c channel switch against an integer model.
  assumes the master model in its own file and clk_en held high.
*/
`timescale 1ns/10ps
module tb_top;
  logic       clock;
  logic       rst_n;
  logic       scl;
  logic       sda_pull;
  logic       sda_oe;
  logic       sda_out;
  logic       ack;
  logic [2:0] strap;
  logic [7:0] chan_en;
  logic [7:0] channel_select;
  logic [7:0] rx;
  int         n_errors;
  int         check_count;
  int         m_sel;
  int         m_en;
  wire        sda_wire;
  // sda has a pull-up: released means high
  assign sda_wire = ~(sda_pull | (sda_oe & ~sda_out));
  i2csw_top i2csw_top_inst (.clock(clock), .rst_n(rst_n), .clk_en(1'b1), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_bit0(strap[0]),
    .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]), .chan_en(chan_en),
    .channel_select(channel_select));
  i2csw_master_model i2csw_master_model_inst (.clock(clock), .sda_wire(sda_wire),
    .scl(scl), .sda_pull(sda_pull));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic x(input logic [7:0] t, input logic nb);
    i2csw_master_model_inst.xfer(t, nb, rx, ack);
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
  endtask
  // address phase: hi nibble, straps, direction
  task automatic addr(input logic [3:0] hi, input logic rw, input logic exp_ack);
    i2csw_master_model_inst.start();
    x({hi, strap, rw}, 1'b1);
    check({7'h0, ack}, {7'h0, exp_ack});
  endtask
  task automatic wr_burst(input int n);
    addr(4'he, 1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      m_sel = $urandom() & 255;
      x(8'(m_sel), 1'b1);
      check({7'h0, ack}, 8'h00);
    end
    cycles(8);
    check(channel_select, 8'(m_sel));
    check(chan_en, 8'(m_en));
    i2csw_master_model_inst.stop();
    m_en = m_sel;
    cycles(8);
    check(chan_en, 8'(m_en));
  endtask
  task automatic rd_burst(input int n);
    addr(4'he, 1'b1, 1'b0);
    for (int i = 0; i < n; i++) begin
      x(8'hff, i == n - 1);
      check(rx, 8'(m_sel));
    end
    i2csw_master_model_inst.stop();
    cycles(8);
    check({7'h0, sda_oe}, 8'h00);
    check(chan_en, 8'(m_en));
  endtask
  initial begin
    rst_n = 1'b0;
    strap = 3'h0;
    n_errors = 0;
    check_count = 0;
    m_sel = 0;
    m_en = 0;
    void'($urandom(81));
    cycles(2);
    rst_n <= 1'b1;
    cycles(4);
    check(channel_select, 8'h00);
    check(chan_en, 8'h00);
    for (int s = 0; s < 8; s++) begin
      strap <= s[2:0];
      cycles(4);
      wr_burst(s % 3 + 1);
      rd_burst(s % 3 + 2);
    end
    // other address: no ack, register left alone
    addr(4'hd, 1'b0, 1'b1);
    x(8'h5a, 1'b1);
    i2csw_master_model_inst.stop();
    cycles(8);
    check(channel_select, 8'(m_sel));
    check(chan_en, 8'(m_en));
    // reset in mid-frame, then a stop that must not connect anything
    addr(4'he, 1'b0, 1'b0);
    x(8'ha5, 1'b1);
    rst_n <= 1'b0;
    cycles(2);
    rst_n <= 1'b1;
    cycles(4);
    check(channel_select, 8'h00);
    check(chan_en, 8'h00);
    i2csw_master_model_inst.stop();
    cycles(8);
    check(chan_en, 8'h00);
    tally_and_finish();
  end
  // a full run needs about 9000 clocks
  initial begin
    cycles(60000);
    n_errors++;
    tally_and_finish();
  end
endmodule
